// ---- pkg/agf_consts.svh ----
// offsets, field positions, reset values and timing counts of the filter configuration block
// Overview of operation
// - low-power accel averages 4/8/16/32 by bits 5:4, one sample in bypass
// - bypass bit 3 skips lowpass, 4 kHz rate
// - bypass clear: lowpass select bits 2:0, 1 kHz
// - output rate is filter rate over divider+1
// - duty-cycle accel: on for averaging, then idle
// - gyro cycle-enable bit 7, resets to zero
// - gyro averages 1..128 by bits 6:4, reset zero
// - gyro low-power ignores gyro lowpass selection
`ifndef AGF_CONSTS_SVH
`define AGF_CONSTS_SVH
// ****************************************
// register byte addresses (index times four)
// ****************************************
`define AGF_IDX_ACCEL_FILTER_CONFIG  8'h1D
`define AGF_IDX_LOW_POWER_MODE_CONFIG 8'h1E
`define AGF_IDX_RATE_DIVIDER         8'h19
`define AGF_IDX_CONTROL              8'h70
`define AGF_IDX_STATUS               8'h71
`define AGF_ADDR_ACCEL_FILTER_CONFIG  12'h074
`define AGF_ADDR_LOW_POWER_MODE_CONFIG 12'h078
`define AGF_ADDR_RATE_DIVIDER         12'h064
`define AGF_ADDR_CONTROL              12'h1C0
`define AGF_ADDR_STATUS               12'h1C4
// ****************************************
// field positions and masks
// ****************************************
`define AGF_ACFG_MASK        8'h3F
`define AGF_LPCFG_MASK       8'hF0
`define AGF_CTRL_MASK        8'h03
`define AGF_ACFG_AVG_LSB     4
`define AGF_ACFG_BYPASS_BIT  3
`define AGF_LPCFG_CYCLE_BIT  7
`define AGF_LPCFG_AVG_LSB    4
`define AGF_CTRL_ACCEL_LP_BIT 0
// ****************************************
// reset values
// ****************************************
`define AGF_ACFG_RESET   8'h00
`define AGF_LPCFG_RESET  8'h00
`define AGF_DIV_RESET    8'h00
`define AGF_CTRL_RESET   8'h00
// ****************************************
// timing: 200 MHz clock, filter rates in Hz
// ****************************************
`define AGF_CLK_HZ        200000000
`define AGF_RATE_LP_HZ    1000
`define AGF_RATE_BYP_HZ   4000
`define AGF_TICKS_LP      (`AGF_CLK_HZ / `AGF_RATE_LP_HZ)
`define AGF_TICKS_BYP     (`AGF_CLK_HZ / `AGF_RATE_BYP_HZ)
`endif

// ---- pkg/agf_pkg.sv ----
// types shared by the filter configuration block
package agf_pkg;
  // accelerometer duty-cycle state
  typedef enum logic [1:0] {
    AGF_IDLE = 2'b00,
    AGF_ON   = 2'b01
  } agf_duty_t;
  // datapath path selection; status reports only the bypass bit, not this type
  typedef enum logic [1:0] {
    AGF_PATH_LOWPASS = 2'b00,
    AGF_PATH_BYPASS  = 2'b01,
    AGF_PATH_AVERAGE = 2'b10
  } agf_path_t;
endpackage : agf_pkg

// ---- verilog/agf_rate_div.sv ----
// filter sample tick generator and output rate divider
`timescale 1ns/100ps
`include "agf_consts.svh"
module agf_rate_div #(
  parameter int TICKS_LP  = `AGF_TICKS_LP,
  parameter int TICKS_BYP = `AGF_TICKS_BYP
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic       bypass,
  input  wire logic [7:0] divider,
  output logic            filt_tick,
  output logic            out_strobe
);
  // elaboration check: counts must fit the 16-bit tick counter
  if (TICKS_LP < 2 || TICKS_LP > 65535 || TICKS_BYP < 2 || TICKS_BYP > TICKS_LP)
    $error("agf_rate_div: tick counts out of range");
  logic [15:0] tick_cnt;            // cycles within one filter sample period
  logic [7:0]  div_cnt;             // filter samples left before next output
  wire  [15:0] tick_top = bypass ? 16'(TICKS_BYP - 1) : 16'(TICKS_LP - 1);
  wire         tick_end = (tick_cnt >= tick_top);
  wire         div_wrap = tick_end && (div_cnt == 8'h00);
  // ****************************************
  // filter sample tick
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt  <= 16'h0000;
      filt_tick <= 1'b0;
    end
    else if (ce)
    begin
      tick_cnt  <= tick_end ? 16'h0000 : tick_cnt + 16'h0001;
      filt_tick <= tick_end;
    end
  end
  // ****************************************
  // divider: reload on wrap, strobe once per divider+1 samples
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt    <= 8'h00;
      out_strobe <= 1'b0;
    end
    else if (ce)
    begin
      if (tick_end)
        div_cnt <= (div_cnt == 8'h00) ? divider : div_cnt - 8'h01;
      out_strobe <= div_wrap;
    end
  end
  // a strobe comes only on a filter tick edge
  strobe_on_tick_a : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && out_strobe) |-> filt_tick)
    else $error("output strobe without filter tick");
endmodule : agf_rate_div

// ---- verilog/agf_filter_cfg.sv ----
// accel/gyro filter and low-power configuration block with apb slave
`timescale 1ns/100ps
`include "agf_consts.svh"
module agf_filter_cfg #(
  parameter int TICKS_LP  = `AGF_TICKS_LP,  // clock cycles per 1 kHz filter sample
  parameter int TICKS_BYP = `AGF_TICKS_BYP  // clock cycles per 4 kHz filter sample
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             accel_power_on,
  output logic             accel_sample_take,
  output logic             accel_filter_bypass,
  output logic      [2:0]  accel_lowpass_sel,
  output logic      [5:0]  accel_avg_count,
  output logic             gyro_lp_enable,
  output logic      [7:0]  gyro_avg_count,
  output logic             gyro_lowpass_use,
  output logic             sample_strobe
);
  // ****************************************
  // registers
  // ****************************************
  logic [7:0] accel_filter_config;     // average select, bypass, lowpass select
  logic [7:0] low_power_mode_config;   // gyro cycle enable and average select
  logic [7:0] output_rate_divider;     // output rate divider value
  logic [7:0] control;                 // accel low-power enable
  agf_pkg::agf_duty_t duty;            // accel duty-cycle state
  logic [5:0] avg_left;                // accel samples left in current set
  logic       set_done;                // sticky: last averaging set completed

  // averaging depth from two-bit code: 4, 8, 16, 32
  function automatic logic [5:0] accel_depth(input logic [1:0] code);
    accel_depth = 6'(6'h04 << code);
  endfunction : accel_depth

  // ****************************************
  // apb decode, zero wait states
  // ****************************************
  wire       acc_phase = psel && penable;
  wire       hit_acfg  = (paddr == `AGF_ADDR_ACCEL_FILTER_CONFIG);
  wire       hit_lpcfg = (paddr == `AGF_ADDR_LOW_POWER_MODE_CONFIG);
  wire       hit_div   = (paddr == `AGF_ADDR_RATE_DIVIDER);
  wire       hit_ctrl  = (paddr == `AGF_ADDR_CONTROL);
  wire       hit_stat  = (paddr == `AGF_ADDR_STATUS);
  wire       hit_any   = hit_acfg || hit_lpcfg || hit_div || hit_ctrl || hit_stat;
  wire       wr_lane0  = acc_phase && pwrite && pstrb[0];
  // status shows block state: path, duty state, set done
  wire       accel_lp  = control[`AGF_CTRL_ACCEL_LP_BIT];
  wire       bypass_b  = accel_filter_config[`AGF_ACFG_BYPASS_BIT];
  wire       gyro_lp   = low_power_mode_config[`AGF_LPCFG_CYCLE_BIT];
  wire [7:0] status    = {3'b000, set_done, gyro_lp, duty == agf_pkg::AGF_ON, bypass_b, accel_lp};
  logic [7:0] next_rdata;
  // reserved bits masked on read as well as write
  always_comb
  begin
    if (hit_acfg)
      next_rdata = accel_filter_config & `AGF_ACFG_MASK;
    else if (hit_lpcfg)
      next_rdata = low_power_mode_config & `AGF_LPCFG_MASK;
    else if (hit_div)
      next_rdata = output_rate_divider;
    else if (hit_ctrl)
      next_rdata = control;
    else if (hit_stat)
      next_rdata = status;
    else
      next_rdata = 8'h00;
  end

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accel_filter_config   <= `AGF_ACFG_RESET;
      low_power_mode_config <= `AGF_LPCFG_RESET;
      output_rate_divider   <= `AGF_DIV_RESET;
      control               <= `AGF_CTRL_RESET;
    end
    else if (ce && wr_lane0)
    begin
      if (hit_acfg)
        accel_filter_config <= pwdata[7:0] & `AGF_ACFG_MASK;
      else if (hit_lpcfg)
        low_power_mode_config <= pwdata[7:0] & `AGF_LPCFG_MASK;
      else if (hit_div)
        output_rate_divider <= pwdata[7:0];
      else if (hit_ctrl)
        control <= pwdata[7:0] & `AGF_CTRL_MASK;
    end
  end

  // ****************************************
  // apb answer: data and error registered at the end of the setup cycle
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      // ready answers the setup cycle, so access completes on its first edge
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata  <= (psel && !penable && !pwrite) ? {24'h000000, next_rdata} : 32'h0000_0000;
    end
  end

  // ****************************************
  // rate division
  // ****************************************
  wire filt_tick;
  wire out_tick;
  agf_rate_div #(
    .TICKS_LP  (TICKS_LP),
    .TICKS_BYP (TICKS_BYP)
  ) u_div (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .bypass     (bypass_b),
    .divider    (output_rate_divider),
    .filt_tick  (filt_tick),
    .out_strobe (out_tick)
  );

  // ****************************************
  // accel duty cycle: wake on output tick, take the set, sleep
  // ****************************************
  wire [5:0] depth = accel_depth(accel_filter_config[5:4]);
  wire       last  = (avg_left == 6'h01);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      duty     <= agf_pkg::AGF_IDLE;
      avg_left <= 6'h00;
      set_done <= 1'b0;
    end
    else if (ce)
    begin
      // a read of status clears done; a new completion in the same cycle wins
      if (acc_phase && !pwrite && hit_stat)
        set_done <= 1'b0;
      case (duty)
        agf_pkg::AGF_IDLE:
        begin
          // bypass path takes one sample; otherwise the averaging depth
          if (accel_lp && out_tick)
          begin
            duty     <= agf_pkg::AGF_ON;
            avg_left <= bypass_b ? 6'h01 : depth;
          end
        end
        agf_pkg::AGF_ON:
        begin
          if (!accel_lp)
            duty <= agf_pkg::AGF_IDLE;
          else if (filt_tick)
          begin
            avg_left <= avg_left - 6'h01;
            if (last)
            begin
              duty     <= agf_pkg::AGF_IDLE;
              set_done <= 1'b1;
            end
          end
        end
        default: duty <= agf_pkg::AGF_IDLE;
      endcase
    end
  end

  // ****************************************
  // registered datapath controls
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accel_power_on      <= 1'b0;
      accel_sample_take   <= 1'b0;
      accel_filter_bypass <= 1'b0;
      accel_lowpass_sel   <= 3'h0;
      accel_avg_count     <= 6'h00;
      gyro_lp_enable      <= 1'b0;
      gyro_avg_count      <= 8'h00;
      gyro_lowpass_use    <= 1'b0;
      sample_strobe       <= 1'b0;
    end
    else if (ce)
    begin
      // low-noise mode keeps the accel powered
      accel_power_on      <= !accel_lp || (duty == agf_pkg::AGF_ON);
      accel_sample_take   <= filt_tick && (!accel_lp || duty == agf_pkg::AGF_ON);
      accel_filter_bypass <= bypass_b;
      accel_lowpass_sel   <= bypass_b ? 3'h0 : accel_filter_config[2:0];
      accel_avg_count     <= (accel_lp && !bypass_b) ? depth : 6'h01;
      gyro_lp_enable      <= gyro_lp;
      // 2^code averages in gyro low power
      gyro_avg_count      <= gyro_lp ? 8'(8'h01 << low_power_mode_config[6:4]) : 8'h01;
      gyro_lowpass_use    <= !gyro_lp;
      sample_strobe       <= out_tick;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  bypass_lowpass_a : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && bypass_b) |=> (!ce || accel_lowpass_sel == 3'h0))
    else $error("lowpass selection not ignored in bypass");
  gyro_lp_avg_a : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && gyro_lp && low_power_mode_config[6:4] == 3'h7) |=> (!ce || gyro_avg_count == 8'h80))
    else $error("gyro averaging depth wrong");
  gyro_no_lpf_a : assert property (@(posedge pclk) disable iff (!presetn)
    gyro_lp_enable |-> !gyro_lowpass_use)
    else $error("gyro lowpass used in low power");
  accel_depth_a : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && accel_lp && !bypass_b && accel_filter_config[5:4] == 2'h3) |=> (!ce || accel_avg_count == 6'h20))
    else $error("accel averaging depth wrong");
  duty_wake_a : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && duty == agf_pkg::AGF_IDLE && accel_lp && out_tick) |=> (!ce || duty == agf_pkg::AGF_ON))
    else $error("accel not woken on output tick");
  reserved_zero_a : assert property (@(posedge pclk) disable iff (!presetn)
    (low_power_mode_config[3:0] == 4'h0) && (accel_filter_config[7:6] == 2'h0))
    else $error("reserved bits not zero");
  cycle_reset_a : assert property (@(posedge pclk)
    $rose(presetn) |-> !low_power_mode_config[7])
    else $error("cycle bit not zero after reset");
  strobe_follow_a : assert property (@(posedge pclk) disable iff (!presetn)
    (ce && out_tick) |=> (!ce || sample_strobe))
    else $error("sample strobe missing");
endmodule : agf_filter_cfg

// ---- tb/test_accel_gyro_filter_lowpower_cfg.sv ----
// self-checking bench for the accel/gyro filter and low-power configuration block
`timescale 1ns/100ps
`include "agf_consts.svh"
module test_accel_gyro_filter_lowpower_cfg;
  // ****************************************
  // signals and clock
  // ****************************************
  localparam int TLP = 8;        // shortened tick count of the 1 kHz path
  localparam int TBY = 4;        // shortened tick count of the 4 kHz path
  logic        pclk;             // 200 MHz bus clock
  logic        presetn;          // async reset, active low
  logic        ce;               // clock enable, high except for the 40-cycle freeze check
  logic        psel;             // apb select
  logic        penable;          // apb enable
  logic        pwrite;           // apb direction
  logic [11:0] paddr;            // apb byte address
  logic [31:0] pwdata;           // apb write data
  logic [3:0]  pstrb;            // apb strobes
  logic [31:0] prdata;           // apb read data
  logic        pready;           // apb ready
  logic        pslverr;          // apb error
  logic        a_on;             // accel powered
  logic        a_take;           // accel sample pulse
  logic        a_byp;            // bypass in use
  logic [2:0]  a_sel;            // accel lowpass choice
  logic [5:0]  a_avg;            // accel averaging depth
  logic        g_en;             // gyro low-power on
  logic [7:0]  g_avg;            // gyro averaging depth
  logic        g_use;            // gyro lowpass in use
  logic        strobe;           // divided output sample
  int          failures;         // mismatches seen
  int          checks;           // comparisons made
  int          cycles;           // cycles since start, for the hang guard
  logic [31:0] rd;               // last read data
  logic        err;              // last error flag
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  agf_filter_cfg #(.TICKS_LP(TLP), .TICKS_BYP(TBY)) dut_u (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .accel_power_on(a_on), .accel_sample_take(a_take),
    .accel_filter_bypass(a_byp), .accel_lowpass_sel(a_sel), .accel_avg_count(a_avg),
    .gyro_lp_enable(g_en), .gyro_avg_count(g_avg), .gyro_lowpass_use(g_use),
    .sample_strobe(strobe));
  // ****************************************
  // shared tasks
  // ****************************************
  // closing report, the single exit of the run
  task automatic stop_test;
    $display("counts: checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  // compare one value, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // one apb transfer; request held until pready is seen high at an edge or 50 edges pass
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(32'(n < 50), 32'h1, "ready wait");
  endtask : apb
  // write then let the registered outputs settle
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(32'(err), 32'h0, "write error");
    repeat (3) @(posedge pclk);
  endtask : wreg
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "read data");
  endtask : rchk
  // count edges until the next output strobe, bounded
  // bound covers a full 256-sample period plus a leftover count from an older divider
  task automatic wstrobe(output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (strobe !== 1'b1 && n < 3000);
  endtask : wstrobe
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rchk(`AGF_ADDR_LOW_POWER_MODE_CONFIG, 32'h0);
    chk(32'(g_en), 32'h0, "gyro lp after reset");
    chk(32'(g_avg), 32'h1, "gyro avg after reset");
  endtask : t_reset
  // reserved bits read zero; unmapped place refused
  task automatic t_reserved;
    wreg(`AGF_ADDR_ACCEL_FILTER_CONFIG, 32'hFFFF_FFFF);
    rchk(`AGF_ADDR_ACCEL_FILTER_CONFIG, 32'h3F);
    wreg(`AGF_ADDR_LOW_POWER_MODE_CONFIG, 32'hFFFF_FFFF);
    rchk(`AGF_ADDR_LOW_POWER_MODE_CONFIG, 32'hF0);
    apb(1'b0, 12'h3F0, 32'h0);
    chk(32'(err), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
  endtask : t_reserved
  // every lowpass code, with and without bypass
  task automatic t_accel_path;
    for (int i = 0; i < 8; i++)
    begin
      wreg(`AGF_ADDR_ACCEL_FILTER_CONFIG, 32'(i));
      chk(32'(a_byp), 32'h0, "bypass off");
      chk(32'(a_sel), 32'(i), "lowpass select");
      wreg(`AGF_ADDR_ACCEL_FILTER_CONFIG, 32'(8 + i));
      chk(32'(a_byp), 32'h1, "bypass on");
      chk(32'(a_sel), 32'h0, "select ignored");
    end
  endtask : t_accel_path
  // every gyro averaging code, cycle bit on then off
  task automatic t_gyro;
    for (int c = 0; c < 8; c++)
    begin
      wreg(`AGF_ADDR_LOW_POWER_MODE_CONFIG, 32'(8'h80 | (c << 4)));
      chk(32'(g_en), 32'h1, "gyro lp on");
      chk(32'(g_avg), 32'(1 << c), "gyro avg");
      chk(32'(g_use), 32'h0, "gyro lowpass unused");
      wreg(`AGF_ADDR_LOW_POWER_MODE_CONFIG, 32'(c << 4));
      chk(32'(g_en), 32'h0, "gyro lp off");
      chk(32'(g_use), 32'h1, "gyro lowpass used");
    end
  endtask : t_gyro
  // accel averaging depths in low-power mode
  task automatic t_accel_avg;
    wreg(`AGF_ADDR_CONTROL, 32'h1);
    for (int c = 0; c < 4; c++)
    begin
      wreg(`AGF_ADDR_ACCEL_FILTER_CONFIG, 32'((c << 4) | 7));
      chk(32'(a_avg), 32'(4 << c), "accel avg");
    end
    wreg(`AGF_ADDR_CONTROL, 32'h0);
  endtask : t_accel_avg
  // strobe spacing for divider values 0, 3 and 255 on the 1 kHz path and divider 3 on the 4 kHz path
  task automatic t_rate;
    int n;
    int dv[3] = '{0, 3, 255};
    for (int k = 0; k < 3; k++)
    begin
      wreg(`AGF_ADDR_ACCEL_FILTER_CONFIG, 32'h0);
      wreg(`AGF_ADDR_RATE_DIVIDER, 32'(dv[k]));
      wstrobe(n);
      wstrobe(n);
      wstrobe(n);
      chk(32'(n), 32'((dv[k] + 1) * TLP), "lowpass period");
    end
    wreg(`AGF_ADDR_ACCEL_FILTER_CONFIG, 32'h8);
    wreg(`AGF_ADDR_RATE_DIVIDER, 32'h3);
    wstrobe(n);
    wstrobe(n);
    wstrobe(n);
    chk(32'(n), 32'(4 * TBY), "bypass period");
    // clock enable low freezes the divider: no strobe while held
    ce <= 1'b0;
    n = 0;
    repeat (40)
    begin
      @(posedge pclk);
      n += (strobe === 1'b1);
    end
    ce <= 1'b1;
    chk(32'(n), 32'h0, "strobe frozen");
  endtask : t_rate
  // duty cycle: one averaging set per output period, idle after
  task automatic t_duty;
    int n;
    int takes;
    int offs;
    wreg(`AGF_ADDR_CONTROL, 32'h1);
    wreg(`AGF_ADDR_ACCEL_FILTER_CONFIG, 32'h07);
    wreg(`AGF_ADDR_RATE_DIVIDER, 32'h7);
    wstrobe(n);
    wstrobe(n);
    takes = 0;
    offs = 0;
    repeat (8 * TLP)
    begin
      @(posedge pclk);
      takes += (a_take === 1'b1);
      offs += (a_on === 1'b0);
    end
    chk(32'(takes), 32'h4, "samples per period");
    chk(32'(offs > 0), 32'h1, "accel idles");
    wreg(`AGF_ADDR_CONTROL, 32'h0);
    // status: completed set is sticky, duty idle, then cleared by the read
    rchk(`AGF_ADDR_STATUS, 32'h10);
    rchk(`AGF_ADDR_STATUS, 32'h00);
  endtask : t_duty
  // ****************************************
  // main sequence and hang guard
  // ****************************************
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      $display("MISMATCH t=%0t run too long", $time);
      stop_test();
    end
  end
  initial
  begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    failures = 0;
    checks = 0;
    cycles = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_reset();
    t_reserved();
    t_accel_path();
    t_gyro();
    t_accel_avg();
    t_rate();
    t_duty();
    stop_test();
  end
endmodule : test_accel_gyro_filter_lowpower_cfg
